// ==== hdl/gtlr_pkg.sv ====
// Constants and types for the talker/listener register front end
// How it works
// (R01) Sixteen byte registers relative to a base; hidden ones via aux port.
// (R02) Listener bytes latch into input latch at 1; writes there don't disturb it.
// (R03) Ready-for-data stays false while the input latch holds an unread byte.
// (R04) Without holdoff, handshake finishes by itself once the byte is read.
// (R05) In holdoff mode handshake waits for finish-handshake; rereads allowed.
// (R06) Latch bit 0 is line DIO1, bit 7 is DIO8, both directions.
// (R07) Writing the output latch queues the byte for the source handshake; a write with both buffer entries full is dropped.
// (R08) Status register at 3 clears on read; mask register shares offset 3.
// (R09) Bits 7..0: cmd pass, addr pass, trigger, end, clear, error, out, in.
// (R10) Interrupt request when a status bit is set and enabled.
// (R11) Status bits set and clear regardless of mask bits.
// (R12) Events during a status read are deferred until the read is over.
// (R13) Undecoded commands and following secondaries set cmd pass flag.
// (R14) Undefined-primary flag set by undecoded primary, cleared by decoded.
// (R15) Addressed commands ignored when unaddressed; undecoded ignored if off.
// (R16) After command pass-through, handshake holds until valid command 017.
// (R17) Address mode 3 secondary in primary-addressed state sets addr pass.
// (R18) While addr pass holds, data-accepted withheld until valid or invalid.
// (R19) Trigger flag set on group execute trigger while listener.
// (R20) End flag set on EOI, or string-end match when enabled, while listening.
// (R21) All status flags clear at reset and right after a status read.
// (R22) Aux config A bit 2 enables string-end reception.
// (R23) Interrupt is OR of enabled status bits, held until bits clear.
package gtlr_pkg;
  localparam logic [3:0] DATA_OFF = 4'h1; // R01
  localparam logic [3:0] STAT_OFF = 4'h3;
  localparam logic [3:0] ADDRESS_MODE_REG_OFF = 4'h9;
  localparam logic [3:0] AUX_OFF = 4'hb;
  localparam logic [3:0] EOS_OFF = 4'hf;
  localparam int B_CPT = 7; // R09
  localparam int B_APT = 6;
  localparam int B_DET = 5;
  localparam int B_END = 4;
  localparam int B_DEC = 3;
  localparam int B_ERR = 2;
  localparam int B_DO = 1;
  localparam int B_DI = 0;
  localparam logic [7:0] AUX_VALID = 8'h0f;
  localparam logic [7:0] AUX_NVALID = 8'h07;
  localparam logic [7:0] AUX_FH = 8'h03;
  localparam logic [2:0] AUXA_PFX = 3'h4;
  localparam logic [2:0] AUXB_PFX = 3'h5;
  localparam int STRING_END_ACCEPT_ENABLE_BIT = 2;
  localparam int HOLD_BIT = 0;
  localparam int PTE_BIT = 0;
  localparam logic [1:0] ADM_MODE3 = 2'h3;
  localparam logic [7:0] CMD_MASK = 8'h7f;
  localparam logic [7:0] CMD_GET = 8'h08;
  localparam logic [7:0] CMD_SDC = 8'h04;
  localparam logic [7:0] CMD_DCL = 8'h14;
  localparam int CLK_NS = 50;
  localparam int SETTLE_NS = 2000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  typedef enum logic [2:0] {
    C_ACG, C_UCG, C_LAG, C_TAG, C_SCG
  } gtlr_cls_t;
  typedef enum logic [1:0] {A_IDLE, A_RDY, A_HOLD, A_DONE} gtlr_acc_t;
  typedef enum logic [1:0] {S_IDLE, S_SET, S_DAV, S_REL} gtlr_src_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } gtlr_host_t;
  typedef struct packed {
    logic tads;
    logic lads;
    logic tpas;
    logic lpas;
    logic lacs;
    logic err_evt;
    logic do_evt;
  } gtlr_core_t;
  typedef struct packed {
    gtlr_acc_t acc;
    gtlr_src_t src;
    logic [7:0] din;
    logic full;
    logic hold_fh;
    logic hold_apt;
    logic udp;
    logic [7:0] passthru_readback;
    logic [7:0] status;
    logic [7:0] pend;
    logic [7:0] mask;
    logic string_end_accept_enable;
    logic hold_mode;
    logic pte;
    logic [1:0] address_mode_reg;
    logic [7:0] eos;
    logic [1:0][7:0] buf_q;
    logic wp;
    logic rp;
    logic [1:0] cnt;
    logic [5:0] scnt;
    logic [7:0] dio_o;
    logic dio_oe_n;
    logic dav;
    logic rfd;
    logic dac;
    logic [7:0] rdata;
    logic irq;
    logic ordy;
  } gtlr_state_t;
endpackage

// ==== hdl/gtlr_regs.sv ====
// Host register front end with acceptor and source handshakes
`timescale 1ns/1ps
module gtlr_regs (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire gtlr_pkg::gtlr_host_t i_host,
  output logic [7:0] o_rdata,
  input wire gtlr_pkg::gtlr_core_t i_core,
  input wire logic [7:0] i_dio,
  output logic [7:0] o_dio,
  output logic o_dio_oe_n,
  input wire logic i_atn,
  input wire logic i_eoi,
  input wire logic i_dav,
  output logic o_rfd,
  output logic o_dac,
  output logic o_dav,
  input wire logic i_rfd,
  input wire logic i_dac,
  output logic o_out_ready,
  output logic o_irq
);
  gtlr_pkg::gtlr_state_t s;
  gtlr_pkg::gtlr_state_t n;
  logic [7:0] set;
  logic rd_stat;
  logic wr_aux;
  logic aux_valid;
  logic aux_nvalid;
  logic aux_fh;
  logic push;
  logic pop;

  function automatic gtlr_pkg::gtlr_cls_t cls_of(input logic [7:0] b);
    gtlr_pkg::gtlr_cls_t c;
    c = gtlr_pkg::C_SCG;
    if (b[6:4] == 3'h0) begin
      c = gtlr_pkg::C_ACG;
    end else if (b[6:4] == 3'h1) begin
      c = gtlr_pkg::C_UCG;
    end else if (b[6:5] == 2'h1) begin
      c = gtlr_pkg::C_LAG;
    end else if (b[6:5] == 2'h2) begin
      c = gtlr_pkg::C_TAG;
    end
    return c;
  endfunction

  function automatic logic is_defined(input logic [7:0] b);
    return b == gtlr_pkg::CMD_GET || b == gtlr_pkg::CMD_SDC ||
      b == gtlr_pkg::CMD_DCL;
  endfunction

  function automatic logic at(input logic [3:0] off); // R01
    return i_host.addr == off;
  endfunction

  assign rd_stat = i_host.rd && at(gtlr_pkg::STAT_OFF); // R08
  assign wr_aux = i_host.wr && at(gtlr_pkg::AUX_OFF);
  assign aux_valid = wr_aux && i_host.wdata == gtlr_pkg::AUX_VALID;
  assign aux_nvalid = wr_aux && i_host.wdata == gtlr_pkg::AUX_NVALID;
  assign aux_fh = wr_aux && i_host.wdata == gtlr_pkg::AUX_FH;

  always_comb begin
    logic [7:0] cmd;
    gtlr_pkg::gtlr_cls_t cls;
    logic addressed;
    logic prim;
    logic undef_prim;
    n = s;
    set = '0;
    cmd = i_dio & gtlr_pkg::CMD_MASK;
    cls = cls_of(cmd);
    addressed = i_core.tads || i_core.lads;
    prim = cls == gtlr_pkg::C_UCG || cls == gtlr_pkg::C_ACG;
    undef_prim = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    set[gtlr_pkg::B_ERR] = i_core.err_evt;
    set[gtlr_pkg::B_DO] = i_core.do_evt;
    // Host writes; the input latch is never touched here
    if (i_host.wr) begin
      if (at(gtlr_pkg::DATA_OFF)) begin
        push = s.cnt != gtlr_pkg::BUF_DEPTH; // R07
      end else if (at(gtlr_pkg::STAT_OFF)) begin
        n.mask = i_host.wdata; // R08
      end else if (at(gtlr_pkg::ADDRESS_MODE_REG_OFF)) begin
        n.address_mode_reg = i_host.wdata[1:0];
      end else if (at(gtlr_pkg::AUX_OFF)) begin
        if (i_host.wdata[7:5] == gtlr_pkg::AUXA_PFX) begin
          n.string_end_accept_enable = i_host.wdata[gtlr_pkg::STRING_END_ACCEPT_ENABLE_BIT]; // R22
          n.hold_mode = i_host.wdata[gtlr_pkg::HOLD_BIT];
        end else if (i_host.wdata[7:5] == gtlr_pkg::AUXB_PFX) begin
          n.pte = i_host.wdata[gtlr_pkg::PTE_BIT];
        end
      end else if (at(gtlr_pkg::EOS_OFF)) begin
        n.eos = i_host.wdata;
      end
    end
    if (aux_fh) begin
      n.hold_fh = 1'b0; // R05
    end
    // Host reads; unmapped offsets read zero
    if (i_host.rd) begin
      if (at(gtlr_pkg::DATA_OFF)) begin
        n.rdata = s.din;
        n.full = 1'b0; // R03
      end else if (at(gtlr_pkg::STAT_OFF)) begin
        n.rdata = s.status;
      end else if (at(gtlr_pkg::AUX_OFF)) begin
        n.rdata = s.passthru_readback;
      end else begin
        n.rdata = '0;
      end
    end
    // Acceptor handshake
    case (s.acc)
      gtlr_pkg::A_IDLE: begin
        if (!s.full && !s.hold_fh && !i_dav) begin // R03 R04
          n.rfd = 1'b1;
          n.acc = gtlr_pkg::A_RDY;
        end
      end
      gtlr_pkg::A_RDY: begin
        if (i_dav) begin
          n.rfd = 1'b0;
          n.dac = 1'b1;
          n.acc = gtlr_pkg::A_DONE;
          if (i_atn) begin
            n.passthru_readback = cmd; // R13 R17
            undef_prim = prim && !is_defined(cmd) &&
              (cls == gtlr_pkg::C_UCG || addressed); // R15
            if (undef_prim && s.pte) begin
              set[gtlr_pkg::B_CPT] = 1'b1; // R13
              n.udp = 1'b1; // R14
            end else if (s.udp && s.pte && cls == gtlr_pkg::C_SCG) begin
              set[gtlr_pkg::B_CPT] = 1'b1; // R13
            end else if (s.address_mode_reg == gtlr_pkg::ADM_MODE3 &&
                (i_core.tpas || i_core.lpas) &&
                cls == gtlr_pkg::C_SCG) begin
              set[gtlr_pkg::B_APT] = 1'b1; // R17
              n.hold_apt = 1'b1;
            end
            if ((prim && is_defined(cmd)) || cls == gtlr_pkg::C_TAG ||
                cls == gtlr_pkg::C_LAG) begin
              n.udp = 1'b0; // R14
            end
            if (cmd == gtlr_pkg::CMD_GET && i_core.lads) begin
              set[gtlr_pkg::B_DET] = 1'b1; // R19
            end
            if (cmd == gtlr_pkg::CMD_DCL ||
                (cmd == gtlr_pkg::CMD_SDC && i_core.lads)) begin
              set[gtlr_pkg::B_DEC] = 1'b1;
            end
            if (set[gtlr_pkg::B_CPT] || set[gtlr_pkg::B_APT]) begin
              n.dac = 1'b0; // R16 R18
              n.acc = gtlr_pkg::A_HOLD;
            end
          end else if (i_core.lacs) begin
            n.din = i_dio; // R02 R06
            n.full = 1'b1;
            set[gtlr_pkg::B_DI] = 1'b1;
            if (i_eoi || (s.string_end_accept_enable && i_dio == s.eos)) begin
              set[gtlr_pkg::B_END] = 1'b1; // R20 R22
            end
            n.hold_fh = s.hold_mode; // R05
          end
        end
      end
      gtlr_pkg::A_HOLD: begin
        if (aux_valid || (s.hold_apt && aux_nvalid)) begin // R16 R18
          n.dac = 1'b1;
          n.hold_apt = 1'b0;
          n.acc = gtlr_pkg::A_DONE;
        end
      end
      default: begin
        if (!i_dav) begin
          n.dac = 1'b0;
          n.acc = gtlr_pkg::A_IDLE;
        end
      end
    endcase
    if (!n.pte) begin
      n.udp = 1'b0; // R14
    end
    // Source handshake drains the output buffer
    case (s.src)
      gtlr_pkg::S_IDLE: begin
        if (s.cnt != 2'h0 && i_rfd && !i_dac) begin
          n.dio_o = s.buf_q[s.rp]; // R06 R07
          n.dio_oe_n = 1'b0;
          n.scnt = 6'(gtlr_pkg::SETTLE_CYC - 1);
          n.src = gtlr_pkg::S_SET;
        end
      end
      gtlr_pkg::S_SET: begin
        if (s.scnt == 6'h0) begin
          n.dav = 1'b1;
          n.src = gtlr_pkg::S_DAV;
        end else begin
          n.scnt = s.scnt - 6'h1;
        end
      end
      gtlr_pkg::S_DAV: begin
        if (i_dac) begin
          n.dav = 1'b0;
          pop = 1'b1;
          n.src = gtlr_pkg::S_REL;
        end
      end
      default: begin
        if (!i_dac) begin
          n.dio_oe_n = 1'b1;
          n.src = gtlr_pkg::S_IDLE;
        end
      end
    endcase
    if (push) begin
      n.buf_q[s.wp] = i_host.wdata;
      n.wp = !s.wp;
    end
    if (pop) begin
      n.rp = !s.rp;
    end
    n.cnt = 2'(s.cnt + {1'b0, push} - {1'b0, pop});
    n.ordy = n.cnt != gtlr_pkg::BUF_DEPTH;
    // Events in a status read cycle wait one cycle in pend
    if (rd_stat) begin
      n.status = '0; // R21
      n.pend = s.pend | set; // R12
    end else begin
      n.status = s.status | s.pend | set; // R11
      n.pend = '0;
    end
    n.irq = |(s.status & s.mask); // R10 R23
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s <= '{acc: gtlr_pkg::A_IDLE, src: gtlr_pkg::S_IDLE,
        dio_oe_n: 1'b1, default: '0}; // R21
    end else if (i_ce) begin
      s <= n;
    end
  end

  assign o_rdata = s.rdata;
  assign o_dio = s.dio_o;
  assign o_dio_oe_n = s.dio_oe_n;
  assign o_rfd = s.rfd;
  assign o_dac = s.dac;
  assign o_dav = s.dav;
  assign o_out_ready = s.ordy;
  assign o_irq = s.irq;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  rfd_while_full_a: assert property ( // R03
    s.full |-> !s.rfd)
    else $error("ready asserted with unread input byte");
  holdoff_rfd_a: assert property ( // R05
    s.hold_fh |-> !s.rfd)
    else $error("ready asserted during holdoff");
  din_keep_a: assert property ( // R02
    i_ce && i_host.wr && at(gtlr_pkg::DATA_OFF) &&
    s.acc != gtlr_pkg::A_RDY |=> $stable(s.din))
    else $error("output write disturbed input latch");
  stat_clear_a: assert property ( // R21
    i_ce && rd_stat |=> s.status == 8'h00)
    else $error("status not cleared after read");
  stat_defer_a: assert property ( // R12
    i_ce && rd_stat && set != 8'h00 |=> s.pend != 8'h00)
    else $error("event during status read lost");
  pend_apply_a: assert property ( // R12
    i_ce && s.pend != 8'h00 && !rd_stat |=>
    (s.status & $past(s.pend)) == $past(s.pend))
    else $error("deferred event not applied");
  irq_gate_a: assert property ( // R10
    i_ce && (s.status & s.mask) != 8'h00 |=> s.irq)
    else $error("enabled status without interrupt");
  mask_write_a: assert property ( // R08
    i_ce && i_host.wr && at(gtlr_pkg::STAT_OFF) |=>
    s.mask == $past(i_host.wdata))
    else $error("mask write not stored");
  cpt_hold_a: assert property ( // R16
    i_ce && s.acc == gtlr_pkg::A_HOLD && !s.hold_apt && !aux_valid
    |=> s.acc == gtlr_pkg::A_HOLD && !s.dac)
    else $error("command pass hold released early");
  apt_hold_a: assert property ( // R18
    s.hold_apt |-> !s.dac)
    else $error("data accepted during address pass");
  src_start_a: assert property ( // R07
    i_ce && i_host.wr && at(gtlr_pkg::DATA_OFF) && s.cnt == 2'h0
    |=> s.cnt == 2'h1 ##[1:2] !s.dio_oe_n || s.src == gtlr_pkg::S_IDLE)
    else $error("output write did not queue byte");

  // Register read path
  unmap_zero_a: assert property ( // R01
    i_ce && i_host.rd && !at(gtlr_pkg::DATA_OFF) &&
    !at(gtlr_pkg::STAT_OFF) && !at(gtlr_pkg::AUX_OFF) |=> s.rdata == 8'h00)
    else $error("unmapped read not zero");
  din_read_a: assert property ( // R02
    i_ce && i_host.rd && at(gtlr_pkg::DATA_OFF) |=>
    s.rdata == $past(s.din))
    else $error("input latch read wrong");
  read_frees_a: assert property ( // R03
    i_ce && s.full && i_host.rd && at(gtlr_pkg::DATA_OFF) |=> !s.full)
    else $error("input latch read did not free it");

  // Acceptor side
  auto_ready_a: assert property ( // R04
    i_ce && s.acc == gtlr_pkg::A_IDLE && !s.full && !s.hold_fh &&
    !i_dav |=> s.rfd)
    else $error("ready not raised after read");
  fh_release_a: assert property ( // R05
    i_ce && aux_fh && s.acc != gtlr_pkg::A_RDY |=> !s.hold_fh)
    else $error("finish handshake did not release");
  udp_off_a: assert property ( // R14
    !s.pte |-> !s.udp)
    else $error("undefined primary kept without pass enable");
  det_set_a: assert property ( // R19
    i_ce && s.acc == gtlr_pkg::A_RDY && i_dav && i_atn &&
    (i_dio & gtlr_pkg::CMD_MASK) == gtlr_pkg::CMD_GET && i_core.lads &&
    !rd_stat |=> s.status[gtlr_pkg::B_DET])
    else $error("trigger flag not set");
  end_set_a: assert property ( // R20
    i_ce && s.acc == gtlr_pkg::A_RDY && i_dav && !i_atn && i_core.lacs &&
    i_eoi && !rd_stat |=> s.status[gtlr_pkg::B_END])
    else $error("end flag not set on end signal");

  // Source side
  dio_drive_a: assert property ( // R06
    i_ce && s.src == gtlr_pkg::S_IDLE && s.cnt != 2'h0 && i_rfd &&
    !i_dac |=> s.dio_o == $past(s.buf_q[s.rp]) && !s.dio_oe_n)
    else $error("output byte not driven in order");
  dav_drive_a: assert property ( // R07
    s.dav |-> !s.dio_oe_n)
    else $error("data valid without driven lines");

  // Status and interrupt
  mask_indep_a: assert property ( // R11
    i_ce && !rd_stat && set != 8'h00 |=>
    (s.status & $past(set)) == $past(set))
    else $error("status event not recorded");
  irq_quiet_a: assert property ( // R23
    i_ce && (s.status & s.mask) == 8'h00 |=> !s.irq)
    else $error("interrupt without enabled status");

  cpt_seen_c: cover property (s.acc == gtlr_pkg::A_HOLD && !s.hold_apt);
  apt_seen_c: cover property (s.hold_apt);
  buf_full_c: cover property (s.cnt == gtlr_pkg::BUF_DEPTH);
  end_seen_c: cover property (s.status[gtlr_pkg::B_END]);
  holdoff_seen_c: cover property (s.hold_fh);
endmodule

// ==== tb/gtlr_far.sv ====
// Far-side instrument model: talker and listener
`timescale 1ns/1ps
module gtlr_far (
  input wire logic i_clk,
  input wire logic i_stall,
  input wire logic [7:0] i_dio,
  input wire logic i_dav,
  input wire logic i_rfd,
  input wire logic i_dac,
  output logic [7:0] o_dio,
  output logic o_atn,
  output logic o_eoi,
  output logic o_dav,
  output logic o_rfd,
  output logic o_dac,
  output logic [7:0] o_got,
  output int o_n
);
  initial begin
    {o_dio, o_atn, o_eoi, o_dav, o_rfd, o_dac, o_got} = '0;
    o_n = 0;
  end
  // Acceptor; stall holds ready low
  always @(negedge i_clk) begin
    o_rfd <= !i_stall && !i_dav && !o_dac;
    if (i_dav && o_rfd) begin
      o_got <= i_dio;
      o_n <= o_n + 1;
      o_dac <= 1'b1;
    end else if (!i_dav) begin
      o_dac <= 1'b0;
    end
  end
  task automatic put(input logic [7:0] b, input logic a, e,
                     output logic ok);
    ok = 1'b0;
    for (int k = 0; k < 200 && !ok; k++) begin
      @(negedge i_clk);
      ok = i_rfd;
    end
    o_dio = b;
    o_atn = a;
    o_eoi = e;
    @(negedge i_clk);
    o_dav = ok;
  endtask
  // Released data lines show the inverse of the last byte
  task automatic drop(output logic ok);
    ok = 1'b0;
    for (int k = 0; k < 200 && !ok; k++) begin
      @(negedge i_clk);
      ok = i_dac;
    end
    o_dav = 1'b0;
    o_dio = ~o_dio;
    {o_atn, o_eoi} = 2'b00;
  endtask
endmodule

// ==== tb/gtlr_regs_bench.sv ====
// Self-checking bench for the register front end
`timescale 1ns/1ps
module gtlr_regs_bench;
  logic clk, rst, ce, stall, rfd, dac, odav, oe_n, ordy, irq;
  logic fr, fd, fv, atn, eoi;
  logic [7:0] rdata, dout, din, got, v, b;
  logic [31:0] seed;
  int checks, error_cnt, n, n1;
  gtlr_pkg::gtlr_host_t host;
  gtlr_pkg::gtlr_core_t core;
  gtlr_regs gtlr_regs_inst (.i_clk(clk), .i_sys_rst(rst), .i_ce(ce),
    .i_host(host), .o_rdata(rdata), .i_core(core), .i_dio(din),
    .o_dio(dout), .o_dio_oe_n(oe_n), .i_atn(atn), .i_eoi(eoi),
    .i_dav(fv), .o_rfd(rfd), .o_dac(dac), .o_dav(odav), .i_rfd(fr),
    .i_dac(fd), .o_out_ready(ordy), .o_irq(irq));
  gtlr_far gtlr_far_inst (.i_clk(clk), .i_stall(stall), .i_dio(dout),
    .i_dav(odav), .i_rfd(rfd), .i_dac(dac), .o_dio(din), .o_atn(atn),
    .o_eoi(eoi), .o_dav(fv), .o_rfd(fr), .o_dac(fd), .o_got(got),
    .o_n(n));
  always #25 clk = ~clk;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] x, e);
    checks++;
    if (x !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", s, e, x);
    end
  endtask
  task automatic tmo(input string s);
    error_cnt++;
    $display("MISMATCH %s exp done seen timeout", s);
    conclude();
  endtask
  task automatic rd(input logic [3:0] a, input logic e);
    @(negedge clk);
    host.rd = 1'b1;
    host.addr = a;
    core.err_evt = e;
    @(negedge clk);
    host.rd = 1'b0;
    core.err_evt = 1'b0;
    v = rdata;
  endtask
  task automatic rc(input string s, input logic [3:0] a,
                    input logic [7:0] e);
    rd(a, 1'b0);
    chk(s, v, e);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    host.wr = 1'b1;
    host.addr = a;
    host.wdata = d;
    @(negedge clk);
    host.wr = 1'b0;
  endtask
  task automatic wrfd();
    for (int k = 0; k < 100 && rfd !== 1'b1; k++) @(negedge clk);
    if (rfd !== 1'b1) tmo("rfd");
  endtask
  task automatic pt(input logic [7:0] c, input logic a, e);
    logic ok;
    gtlr_far_inst.put(c, a, e, ok);
    if (!ok) tmo("put");
  endtask
  task automatic dr();
    logic ok;
    gtlr_far_inst.drop(ok);
    if (!ok) tmo("drop");
  endtask
  task automatic gb(input logic [7:0] e);
    n1 = n;
    for (int k = 0; k < 200 && n == n1; k++) @(negedge clk);
    if (n == n1) tmo("out");
    chk("out", got, e);
  endtask
  // Command held at accept until the release code
  task automatic hc(input logic [7:0] c, e, r);
    pt(c, 1'b1, 1'b0);
    repeat (5) @(negedge clk);
    chk("dac", 8'(dac), 8'h00);
    rc("stat", 4'h3, e);
    rc("passthru_readback", 4'hb, c);
    wr(4'hb, r);
    dr();
  endtask
  task automatic nh(input logic [7:0] c, e);
    pt(c, 1'b1, 1'b0);
    dr();
    rc("stat", 4'h3, e);
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    stall = 1'b0;
    host = '0;
    core = '0;
    seed = 32'h20;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk("oe_n", 8'(oe_n), 8'h01);
    rc("stat", 4'h3, 8'h00);
    rc("unmap", 4'h5, 8'h00);
    $display("test reset done");
    core.lacs = 1'b1;
    for (int m = 0; m < 4; m++) begin
      b = rnd();
      wr(4'hf, b);
      wr(4'hb, m == 2 ? 8'h84 : 8'h80);
      pt(b, 1'b0, m == 1);
      dr();
      repeat (3) @(negedge clk);
      chk("rfd", 8'(rfd), 8'h00);
      wr(4'h1, ~b);
      rc("din", 4'h1, b);
      rc("stat", 4'h3, m % 3 ? 8'h11 : 8'h01);
      wrfd();
      gb(~b);
    end
    $display("test rx done");
    core.lacs = 1'b0;
    wr(4'h3, 8'h04);
    rd(4'h5, 1'b1);
    repeat (4) @(negedge clk);
    chk("irq", 8'(irq), 8'h01);
    rc("stat", 4'h3, 8'h04);
    repeat (2) @(negedge clk);
    chk("irq", 8'(irq), 8'h00);
    wr(4'h3, 8'h00);
    rd(4'h5, 1'b1);
    repeat (3) @(negedge clk);
    chk("irq", 8'(irq), 8'h00);
    rd(4'h3, 1'b1);
    chk("stat", v, 8'h04);
    rc("stat", 4'h3, 8'h04);
    rc("stat", 4'h3, 8'h00);
    $display("test irq done");
    wr(4'hb, 8'ha1);
    hc(8'h11, 8'h80, 8'h0f);
    hc(8'h65, 8'h80, 8'h0f);
    nh(8'h01, 8'h00);
    wr(4'hb, 8'ha0);
    nh(8'h11, 8'h00);
    wr(4'hb, 8'ha1);
    nh(8'h65, 8'h00);
    wr(4'hb, 8'ha0);
    core.lads = 1'b1;
    nh(8'h08, 8'h20);
    core.lads = 1'b0;
    wr(4'h9, 8'h03);
    core.tpas = 1'b1;
    hc(8'h62, 8'h40, 8'h07);
    core.tpas = 1'b0;
    $display("test cmd done");
    core.lacs = 1'b1;
    wr(4'hb, 8'h81);
    b = rnd();
    pt(b, 1'b0, 1'b0);
    dr();
    rc("din", 4'h1, b);
    repeat (4) @(negedge clk);
    chk("rfd", 8'(rfd), 8'h00);
    rc("din", 4'h1, b);
    wr(4'hb, 8'h03);
    wrfd();
    wr(4'hb, 8'h80);
    rc("stat", 4'h3, 8'h01);
    $display("test holdoff done");
    stall = 1'b1;
    b = rnd();
    wr(4'h1, b);
    wr(4'h1, ~b);
    @(negedge clk);
    chk("ordy", 8'(ordy), 8'h00);
    wr(4'h1, 8'h5a);
    stall = 1'b0;
    gb(b);
    gb(~b);
    n1 = n;
    repeat (60) @(negedge clk);
    chk("drop", 8'(n - n1), 8'h00);
    chk("ordy", 8'(ordy), 8'h01);
    $display("test buffer done");
    ce = 1'b0;
    core.do_evt = 1'b1;
    @(negedge clk);
    core.do_evt = 1'b0;
    ce = 1'b1;
    rc("stat", 4'h3, 8'h00);
    core.do_evt = 1'b1;
    @(negedge clk);
    core.do_evt = 1'b0;
    rc("stat", 4'h3, 8'h02);
    $display("test enable done");
    conclude();
  end
endmodule
